// File: rtl/lrt_pkg.sv
// Purpose: Shared constants and types for the LCD row timing block.
// Assumes: A 50 MHz system clock; the oscillator input arrives as a plain synchronous level.
// Notes: Command codes and timing divisors live here so the design and its bench agree.
package lrt_pkg;

  localparam int unsigned ROWS = 65;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned FRAME_HZ = 35;

  // Row counts per duty select code.
  localparam logic [6:0] DUTY_ROWS_17 = 7'h11;
  localparam logic [6:0] DUTY_ROWS_33 = 7'h21;
  localparam logic [6:0] DUTY_ROWS_49 = 7'h31;
  localparam logic [6:0] DUTY_ROWS_65 = 7'h41;

  // Oscillator frequencies, and half periods in system clocks, for the internal oscillator ranges.
  localparam int unsigned OSC_430K_HZ = 430000;
  localparam int unsigned OSC_215K_HZ = 215000;
  localparam int unsigned OSC_54K_HZ = 54000;
  localparam int unsigned OSC_27K_HZ = 27000;
  localparam logic [11:0] OSC_DIV_430K = 12'((CLK_HZ / OSC_430K_HZ) / 2);
  localparam logic [11:0] OSC_DIV_215K = 12'((CLK_HZ / OSC_215K_HZ) / 2);
  localparam logic [11:0] OSC_DIV_54K = 12'((CLK_HZ / OSC_54K_HZ) / 2);
  localparam logic [11:0] OSC_DIV_27K = 12'((CLK_HZ / OSC_27K_HZ) / 2);

  // Oscillator ticks per row line: 12 at 27 kHz and 1/65 duty, doubled for each faster range.
  localparam logic [9:0] LINE_DIV_BASE = 10'h00c;

  // Command field layout.
  localparam int unsigned CMD_W = 6;
  localparam logic [5:0] CMD_DISP_OFF = 6'h02;
  localparam logic [5:0] CMD_DISP_ON = 6'h03;
  localparam logic [5:0] CMD_BIAS_BASE = 6'h04;
  localparam logic [5:0] CMD_OPAMP_ON = 6'h10;
  localparam logic [5:0] CMD_OPAMP_OFF = 6'h11;
  localparam logic [5:0] CMD_OPLVL_BASE = 6'h14;

  // Settings after reset.
  localparam logic [4:0] RST_CONTRAST = 5'h00;
  localparam logic [1:0] RST_BIAS = 2'h0;
  localparam logic [1:0] RST_OPLVL = 2'h0;
  localparam logic RST_DISP_ON = 1'b0;
  localparam logic RST_OPAMP_ON = 1'b1;

  typedef struct packed {
    logic [4:0] contrast;
    logic [1:0] bias;
    logic [1:0] opamp_level_cmd;
    logic opamp_on;
    logic disp_on;
  } lrt_settings_s;

  // Drive level index per row: 0 selected/phase0, 1 selected/phase1, 2 idle/phase0, 3 idle/phase1.
  typedef logic [1:0] lrt_level_t;

endpackage

// File: rtl/lrt_cmd_decode.sv
// Purpose: Captures host commands on the write and latch strobes and updates the settings.
// Assumes: Strobes and bus are synchronous to clk.
// Notes: A command is taken in the cycle in which either strobe rises after both were low.
`timescale 1ns/1ns
module lrt_cmd_decode (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] command_bus,
  input wire logic write_strobe_n,
  input wire logic latch_strobe_n,
  output lrt_pkg::lrt_settings_s settings
);

  logic strobe_ff;
  logic nxt_strobe;
  lrt_pkg::lrt_settings_s set_ff;
  lrt_pkg::lrt_settings_s nxt_set;
  logic take;

  assign nxt_strobe = ~write_strobe_n & ~latch_strobe_n;
  assign take = strobe_ff & ~nxt_strobe;

  always_comb begin
    nxt_set = set_ff;
    if (take) begin
      if (command_bus[5]) begin
        nxt_set.contrast = command_bus[4:0];
      end else if (command_bus[5:3] == 3'b011) begin
        nxt_set = set_ff;
      end else if (command_bus[5:2] == lrt_pkg::CMD_OPLVL_BASE[5:2]) begin
        nxt_set.opamp_level_cmd = command_bus[1:0];
      end else if (command_bus[5:2] == lrt_pkg::CMD_OPAMP_ON[5:2]) begin
        nxt_set.opamp_on = ~command_bus[0];
      end else if (command_bus[5:2] == lrt_pkg::CMD_BIAS_BASE[5:2]) begin
        nxt_set.bias = command_bus[1:0];
      end else if (command_bus[5:1] == lrt_pkg::CMD_DISP_OFF[5:1]) begin
        nxt_set.disp_on = command_bus[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_ff <= 1'b0;
      set_ff <= '{contrast: lrt_pkg::RST_CONTRAST, bias: lrt_pkg::RST_BIAS,
                  opamp_level_cmd: lrt_pkg::RST_OPLVL, opamp_on: lrt_pkg::RST_OPAMP_ON,
                  disp_on: lrt_pkg::RST_DISP_ON};
    end else begin
      strobe_ff <= nxt_strobe;
      set_ff <= nxt_set;
    end
  end

  assign settings = set_ff;

  chk_test_code_ignored: assert property (@(posedge clk) disable iff (reset)
    (take && command_bus[5:3] == 3'b011) |=> $stable(set_ff)) else $error("Test code changed settings.");
  chk_contrast_load: assert property (@(posedge clk) disable iff (reset)
    (take && command_bus[5]) |=> set_ff.contrast == $past(command_bus[4:0])) else $error("Contrast not loaded.");
  chk_display_cmd: assert property (@(posedge clk) disable iff (reset)
    (take && command_bus[5:1] == 5'h01) |=> set_ff.disp_on == $past(command_bus[0]))
    else $error("Display command not applied.");
  chk_bias_cmd: assert property (@(posedge clk) disable iff (reset)
    (take && command_bus[5:2] == 4'h1) |=> set_ff.bias == $past(command_bus[1:0])) else $error("Bias not applied.");

endmodule

// File: rtl/lrt_row_timing.sv
// What this block does
// - Two duty select pins pick 17, 33, 49 or 65 active rows per frame.
// - Two frequency select pins pick the 430, 215, 54 or 27 kHz oscillator range.
// - The oscillator is divided into the column shift clock, the preframe marker and a half-rate operating clock.
// - When external clock mode is chosen the oscillator input pin drives all timing.
// - While standby is low every internal clock stops and both converter outputs sit at the logic supply level.
// - A 65-stage row shift register, stepped by the line timing, feeds the 65 row outputs.
// - Each row picks one of four drive levels from its shift bit and the frame phase.
// - A command with the top bit set loads its low five bits as contrast.
// - A bias command picks one of four bias ratios in its two low bits.
// - Reset turns the display off and puts the op-amp level at its minimum.
// - Codes 02h and 03h turn the display off and on; off forces every row to the supply level.
// - Codes 04h to 07h pick bias 1/5, 1/7, 1/8 and 1/9.
// - Codes 10h and 11h switch the op-amp on and off and 14h to 17h set its supply level.
//
// Purpose: Timing generator, row scanner and drive level select of an LCD row driver.
// Assumes: osc_in is synchronous to clk; the analog ladder reads the settings outputs.
// Notes: Row levels are encoded indices; level 3 on every row also stands for the supply level.
`timescale 1ns/1ns
module lrt_row_timing (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] duty_select,
  input wire logic [1:0] freq_select,
  input wire logic ext_clock_mode,
  input wire logic osc_in,
  input wire logic standby_n,
  input wire logic [5:0] command_bus,
  input wire logic write_strobe_n,
  input wire logic latch_strobe_n,
  output logic column_shift_clock,
  output logic preframe_marker,
  output logic column_op_clock,
  output logic [129:0] row_outputs,
  output logic converter_out_a,
  output logic converter_out_b,
  output logic [4:0] contrast,
  output logic [1:0] bias_select,
  output logic [1:0] opamp_level_cmd,
  output logic opamp_on
);

  typedef enum logic [1:0] {
    LRT_RUN = 2'b01,
    LRT_STOP = 2'b10
  } lrt_mode_e;

  lrt_pkg::lrt_settings_s settings;
  lrt_mode_e mode_ff, nxt_mode;
  logic [11:0] div_ff, nxt_div;
  logic osc_ff, nxt_osc;
  logic osc_prev_ff;
  logic osc_tick;
  logic phi_ff, nxt_phi;
  logic [9:0] line_ff, nxt_line;
  logic [6:0] row_ff, nxt_row;
  logic frame_ff, nxt_frame;
  logic [lrt_pkg::ROWS-1:0] shift_ff, nxt_shift;
  logic line_pulse_ff, nxt_line_pulse;
  logic marker_ff, nxt_marker;
  logic [129:0] rows_ff, nxt_rows;
  logic [6:0] duty_rows;
  logic [11:0] half_period;
  logic line_end;

  function automatic logic [6:0] duty_to_rows(input logic [1:0] sel);
    unique case (sel)
      2'b00: duty_to_rows = lrt_pkg::DUTY_ROWS_17;
      2'b01: duty_to_rows = lrt_pkg::DUTY_ROWS_33;
      2'b10: duty_to_rows = lrt_pkg::DUTY_ROWS_49;
      2'b11: duty_to_rows = lrt_pkg::DUTY_ROWS_65;
    endcase
  endfunction

  function automatic logic [11:0] freq_to_div(input logic [1:0] sel);
    unique case (sel)
      2'b11: freq_to_div = lrt_pkg::OSC_DIV_430K;
      2'b10: freq_to_div = lrt_pkg::OSC_DIV_215K;
      2'b01: freq_to_div = lrt_pkg::OSC_DIV_54K;
      2'b00: freq_to_div = lrt_pkg::OSC_DIV_27K;
    endcase
  endfunction

  lrt_cmd_decode u_cmd (
    .clk(clk),
    .reset(reset),
    .command_bus(command_bus),
    .write_strobe_n(write_strobe_n),
    .latch_strobe_n(latch_strobe_n),
    .settings(settings)
  );

  assign duty_rows = duty_to_rows(duty_select);
  assign half_period = freq_to_div(freq_select);
  // Each faster range doubles the ticks per line, so at 1/65 duty the frame runs near 35 Hz at 27 and 54 kHz and near 69 Hz at 215 and 430 kHz.
  assign line_end = osc_tick && (line_ff == (lrt_pkg::LINE_DIV_BASE << freq_select) - 10'h001);

  always_comb begin
    nxt_mode = standby_n ? LRT_RUN : LRT_STOP;
    nxt_div = div_ff;
    nxt_osc = osc_ff;
    if (mode_ff == LRT_RUN) begin
      if (ext_clock_mode) begin
        nxt_osc = osc_in;
      end else if (div_ff >= half_period - 12'h001) begin
        nxt_div = 12'h000;
        nxt_osc = ~osc_ff;
      end else begin
        nxt_div = div_ff + 12'h001;
      end
    end
  end

  // Ticks are gated by the run state so no line pulse slips out in the cycle in which standby takes hold.
  assign osc_tick = osc_ff & ~osc_prev_ff & (mode_ff == LRT_RUN);

  always_comb begin
    nxt_phi = phi_ff;
    nxt_line = line_ff;
    nxt_row = row_ff;
    nxt_frame = frame_ff;
    nxt_shift = shift_ff;
    nxt_line_pulse = 1'b0;
    nxt_marker = marker_ff;
    if (osc_tick) begin
      nxt_phi = ~phi_ff;
      nxt_line = line_ff + 10'h001;
    end
    if (line_end) begin
      nxt_line = 10'h000;
      nxt_line_pulse = 1'b1;
      if (row_ff >= duty_rows - 7'h01) begin
        nxt_row = 7'h00;
        nxt_frame = ~frame_ff;
        nxt_shift = {{(lrt_pkg::ROWS-1){1'b0}}, 1'b1};
        nxt_marker = 1'b1;
      end else begin
        nxt_row = row_ff + 7'h01;
        nxt_shift = {shift_ff[lrt_pkg::ROWS-2:0], 1'b0};
        nxt_marker = 1'b0;
      end
    end
  end

  // Level index is {not selected, frame phase}; display off forces the supply level.
  always_comb begin
    nxt_rows = rows_ff;
    for (int i = 0; i < lrt_pkg::ROWS; i++) begin
      if (!settings.disp_on || mode_ff != LRT_RUN) begin
        nxt_rows[2*i +: 2] = 2'b11;
      end else begin
        nxt_rows[2*i +: 2] = {~shift_ff[i], frame_ff};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff <= LRT_STOP;
      div_ff <= 12'h000;
      osc_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
      phi_ff <= 1'b0;
      line_ff <= 10'h000;
      row_ff <= 7'h00;
      frame_ff <= 1'b0;
      shift_ff <= {{(lrt_pkg::ROWS-1){1'b0}}, 1'b1};
      line_pulse_ff <= 1'b0;
      marker_ff <= 1'b0;
      rows_ff <= {130{1'b1}};
    end else begin
      mode_ff <= nxt_mode;
      div_ff <= nxt_div;
      osc_ff <= nxt_osc;
      osc_prev_ff <= osc_ff;
      phi_ff <= nxt_phi;
      line_ff <= nxt_line;
      row_ff <= nxt_row;
      frame_ff <= nxt_frame;
      shift_ff <= nxt_shift;
      line_pulse_ff <= nxt_line_pulse;
      marker_ff <= nxt_marker;
      rows_ff <= nxt_rows;
    end
  end

  // Converter outputs read high when parked at the logic supply.
  always_ff @(posedge clk) begin
    if (reset) begin
      converter_out_a <= 1'b1;
      converter_out_b <= 1'b1;
      contrast <= lrt_pkg::RST_CONTRAST;
      bias_select <= lrt_pkg::RST_BIAS;
      opamp_level_cmd <= lrt_pkg::RST_OPLVL;
      opamp_on <= lrt_pkg::RST_OPAMP_ON;
    end else begin
      converter_out_a <= ~standby_n | ~osc_ff;
      converter_out_b <= ~standby_n | osc_ff;
      contrast <= settings.contrast;
      bias_select <= settings.bias;
      opamp_level_cmd <= settings.opamp_level_cmd;
      opamp_on <= settings.opamp_on;
    end
  end

  assign column_shift_clock = line_pulse_ff;
  assign preframe_marker = marker_ff;
  assign column_op_clock = phi_ff;
  assign row_outputs = rows_ff;

  chk_standby_clocks: assert property (@(posedge clk) disable iff (reset)
    (!standby_n)[*3] |-> $stable(osc_ff) && !column_shift_clock) else $error("Clock ran in standby.");
  chk_converter_park: assert property (@(posedge clk) disable iff (reset)
    !standby_n |=> converter_out_a && converter_out_b) else $error("Converter not parked.");
  chk_phi_half_rate: assert property (@(posedge clk) disable iff (reset)
    osc_tick |=> column_op_clock != $past(column_op_clock)) else $error("Operating clock missed a tick.");
  chk_display_off_rows: assert property (@(posedge clk) disable iff (reset)
    !settings.disp_on |=> row_outputs == {130{1'b1}}) else $error("Rows driven while off.");
  chk_one_hot_scan: assert property (@(posedge clk) disable iff (reset)
    $onehot(shift_ff)) else $error("Row scan not one-hot.");
  chk_frame_wrap: assert property (@(posedge clk) disable iff (reset)
    (line_end && row_ff == duty_rows - 7'h01) |=> row_ff == 7'h00 && preframe_marker) else $error("Frame wrap wrong.");
  chk_ext_clock: assert property (@(posedge clk) disable iff (reset)
    (ext_clock_mode && standby_n && mode_ff == LRT_RUN) |=> osc_ff == $past(osc_in)) else $error("External clock lost.");
  chk_reset_defaults: assert property (@(posedge clk)
    reset |=> !settings.disp_on && settings.opamp_level_cmd == 2'h0) else $error("Reset settings wrong.");
  chk_level_select: assert property (@(posedge clk) disable iff (reset)
    (settings.disp_on && mode_ff == LRT_RUN) |=> row_outputs[1:0] == {~$past(shift_ff[0]), $past(frame_ff)})
    else $error("Row level wrong.");

endmodule

// File: sim/lrt_host_model.sv
// Purpose: Host controller model that writes 6-bit commands with both strobes.
// Assumes: The device takes the word on the edge after the strobes rise.
// Notes: The bus shows the inverted word once released, so a late sample cannot pass by luck.
`timescale 1ns/1ns
module lrt_host_model (
  input wire logic clk,
  output logic [5:0] command_bus,
  output logic write_strobe_n,
  output logic latch_strobe_n
);
  initial begin
    command_bus = 6'h15;
    write_strobe_n = 1'b1;
    latch_strobe_n = 1'b1;
  end

  // Callers only pass test codes when a scenario means them to be ignored.
  task automatic send(input logic [5:0] v);
    @(posedge clk);
    command_bus <= v;
    write_strobe_n <= 1'b0;
    latch_strobe_n <= 1'b0;
    @(posedge clk);
    write_strobe_n <= 1'b1;
    latch_strobe_n <= 1'b1;
    @(posedge clk);
    command_bus <= ~v;
  endtask
endmodule

// File: sim/test_lrt_row_timing.sv
// Purpose: Self-checking bench for the LCD row timing block.
// Assumes: osc_in is made here from a divide-by-four of clk in external clock mode.
// Notes: Oscillator periods are compared as ratios, so the divider rounding does not matter.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module test_lrt_row_timing;
  logic clk = 1'b0, reset = 1'b1, ext_clock_mode = 1'b0, osc_run = 1'b0, osc_in = 1'b0, standby_n = 1'b1;
  logic [1:0] duty_select = 2'h3, freq_select = 2'h3, osc_cnt = 2'h0, e_bias = 2'h0, e_lvl = 2'h0;
  logic [5:0] command_bus;
  logic write_strobe_n, latch_strobe_n, column_shift_clock, preframe_marker, column_op_clock;
  logic converter_out_a, converter_out_b, opamp_on, e_on = 1'b1, v;
  logic [129:0] row_outputs, snap;
  logic [64:0] seen;
  logic [4:0] contrast, e_con = 5'h00;
  logic [1:0] bias_select, opamp_level_cmd;
  int fail_count = 0, tests_run = 0, n, k, iv[4], dummy;
  logic [11:0] dv[4] = '{lrt_pkg::OSC_DIV_27K, lrt_pkg::OSC_DIV_54K, lrt_pkg::OSC_DIV_215K, lrt_pkg::OSC_DIV_430K};

  lrt_host_model host (.clk(clk), .command_bus(command_bus), .write_strobe_n(write_strobe_n),
    .latch_strobe_n(latch_strobe_n));
  lrt_row_timing uut (.clk(clk), .reset(reset), .duty_select(duty_select), .freq_select(freq_select),
    .ext_clock_mode(ext_clock_mode), .osc_in(osc_in), .standby_n(standby_n), .command_bus(command_bus),
    .write_strobe_n(write_strobe_n), .latch_strobe_n(latch_strobe_n), .column_shift_clock(column_shift_clock),
    .preframe_marker(preframe_marker), .column_op_clock(column_op_clock), .row_outputs(row_outputs),
    .converter_out_a(converter_out_a), .converter_out_b(converter_out_b), .contrast(contrast),
    .bias_select(bias_select), .opamp_level_cmd(opamp_level_cmd), .opamp_on(opamp_on));

  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    osc_cnt <= osc_run ? osc_cnt + 2'h1 : osc_cnt;
    osc_in <= osc_cnt[1];
  end

  // Rows per frame for a duty code: 1/17, 1/33, 1/49 and 1/65 step by 16.
  function automatic int exp_rows(input int sel);
    return 17 + 16 * sel;
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [5:0] c);
    host.send(c);
    cyc(3);
  endtask
  task automatic chk_set();
    `CHK("contrast", e_con, contrast);
    `CHK("bias", e_bias, bias_select);
    `CHK("oplevel", e_lvl, opamp_level_cmd);
    `CHK("opamp_on", e_on, opamp_on);
  endtask
  // Time between two toggles of the operating clock, after skipping a partial one.
  task automatic tog(output int t);
    t = 0;
    cyc(1);
    v = column_op_clock;
    while (column_op_clock === v && t < 5000) begin cyc(1); t++; end
    v = column_op_clock;
    t = 0;
    while (column_op_clock === v && t < 5000) begin cyc(1); t++; end
  endtask
  // Line pulses from one frame marker rise to the next.
  task automatic frame(output int f);
    int r, g;
    logic p;
    f = 0; r = 0; g = 0; p = preframe_marker;
    while (r < 2 && g < 20000) begin
      cyc(1);
      g++;
      if (preframe_marker === 1'b1 && p !== 1'b1) r++;
      if (r == 1 && column_shift_clock === 1'b1) f++;
      p = preframe_marker;
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(20 * 90000);
    fail_count++;
    conclude();
  end

  initial begin
    dummy = $urandom(45093);
    cyc(10);
    @(posedge clk) reset <= 1'b0;
    cyc(2);
    chk_set();
    `CHK("rows_off", {130{1'b1}}, row_outputs);
    for (int i = 0; i < 6; i++) begin
      k = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(31);
      e_con = 5'(k);
      cmd({1'b1, e_con});
      chk_set();
    end
    for (int i = 0; i < 4; i++) begin
      e_bias = 2'(i); cmd(6'(lrt_pkg::CMD_BIAS_BASE + i)); chk_set();
      e_lvl = 2'(3 - i); cmd(6'(lrt_pkg::CMD_OPLVL_BASE + 3 - i)); chk_set();
    end
    e_on = 1'b0; cmd(lrt_pkg::CMD_OPAMP_OFF); chk_set();
    e_on = 1'b1; cmd(lrt_pkg::CMD_OPAMP_ON); chk_set();
    for (int i = 0; i < 8; i++) begin
      cmd({3'b011, 3'($urandom_range(7))});
      chk_set();
    end
    // Internal oscillator: periods must scale with the chosen range.
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) freq_select <= 2'(i);
      tog(iv[i]);
    end
    for (int i = 0; i < 3; i++) `CHK("osc_ratio", iv[3] * int'(dv[i]), iv[i] * int'(dv[3]));
    // External clock: a stalled osc_in freezes the operating clock.
    @(posedge clk) begin ext_clock_mode <= 1'b1; freq_select <= 2'h0; end
    cyc(20);
    v = column_op_clock;
    cyc(200);
    `CHK("ext_stall", v, column_op_clock);
    @(posedge clk) osc_run <= 1'b1;
    tog(k);
    // The bench oscillator lasts four clocks, and the operating clock toggles once per oscillator period.
    `CHK("ext_run", 4, k);
    cmd(lrt_pkg::CMD_DISP_ON);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) duty_select <= 2'(i);
      frame(k);
      `CHK("duty_lines", exp_rows(i), k);
    end
    seen = '0;
    repeat (3400) begin
      cyc(1);
      for (int i = 0; i < 65; i++) seen[i] = seen[i] | (row_outputs[2*i+1] === 1'b0);
    end
    `CHK("rows_seen", {65{1'b1}}, seen);
    n = 0; k = 0;
    for (int i = 0; i < 65; i++) begin
      n += int'(row_outputs[2*i+1] === 1'b0);
      k += int'(row_outputs[2*i] !== row_outputs[0]);
    end
    `CHK("one_row_sel", 1, n);
    `CHK("same_phase", 0, k);
    @(posedge clk) standby_n <= 1'b0;
    cyc(3);
    snap = row_outputs;
    v = column_op_clock;
    cyc(300);
    `CHK("standby_conv", 2'h3, {converter_out_a, converter_out_b});
    `CHK("standby_rows", snap, row_outputs);
    `CHK("standby_clk", v, column_op_clock);
    @(posedge clk) standby_n <= 1'b1;
    cmd(lrt_pkg::CMD_DISP_OFF);
    `CHK("rows_off2", {130{1'b1}}, row_outputs);
    e_lvl = 2'h2;
    cmd(6'(lrt_pkg::CMD_OPLVL_BASE + 2));
    chk_set();
    cmd(lrt_pkg::CMD_DISP_ON);
    `CHK("rows_on", 1'b0, &row_outputs);
    @(posedge clk) reset <= 1'b1;
    cyc(2);
    @(posedge clk) reset <= 1'b0;
    e_con = 5'h00; e_bias = 2'h0; e_lvl = 2'h0; e_on = 1'b1;
    cyc(2);
    chk_set();
    `CHK("rows_off3", {130{1'b1}}, row_outputs);
    conclude();
  end
endmodule
